// ### ced_pkg.sv
// Shared constants and types for the configuration error detection checker.
`default_nettype none
package ced_pkg;
    localparam int CED_MSG_W = 46;
    localparam int CED_CRC_W = 16;
    localparam int CED_BIT_W = 12;
    localparam int CED_FRAME_W = 14;
    localparam int CED_TYPE_W = 4;
    localparam int CED_SYN_LSB = 0;
    localparam int CED_LOC_LSB = 16;
    localparam int CED_FRAME_LSB = 28;
    localparam int CED_TYPE_LSB = 42;
    localparam logic [15:0] CED_CRC_POLY = 16'h1021;
    localparam logic [15:0] CED_CRC_INIT = 16'hFFFF;
    localparam logic [45:0] CED_MSG_RESET = 46'h0000_0000_0000;
    localparam logic [3:0] CED_TYPE_SINGLE = 4'h1;
    localparam logic [3:0] CED_TYPE_DOUBLE = 4'h2;
    localparam logic [3:0] CED_TYPE_MULTI = 4'h3;
    localparam logic [3:0] CED_DIV_N_MIN = 4'h1;
    localparam logic [3:0] CED_DIV_N_MAX = 4'h8;
    localparam logic [5:0] CED_FLAG_LOW_TICKS = 6'h20;
    typedef enum logic [2:0] {
        CED_IDLE,
        CED_SCAN,
        CED_CHECK,
        CED_SEARCH,
        CED_WAIT
    } ced_state_t;
endpackage
`default_nettype wire

// ### ced_clkdiv.sv
// Divider that makes the error detection tick from the system clock.
`timescale 1ns/100ps
`default_nettype none
module ced_clkdiv (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic run_i,
    input wire logic [3:0] div_n_i,
    output logic tick_o
);
    import ced_pkg::*;

    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [3:0] n_eff;
    logic [7:0] mask;

    // Out of range settings are clamped so the ratio stays a power of two from 2 to 256.
    always_comb begin
        if (div_n_i < CED_DIV_N_MIN) begin
            n_eff = CED_DIV_N_MIN;
        end else if (div_n_i > CED_DIV_N_MAX) begin
            n_eff = CED_DIV_N_MAX;
        end else begin
            n_eff = div_n_i;
        end
        mask = 8'hFF >> (4'h8 - n_eff);
        next_cnt = run_i ? cnt + 8'h01 : 8'h00;
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt <= 8'h00;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign tick_o = run_i && ((cnt & mask) == mask);

    tick_spacing_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        tick_o |=> !tick_o) else $error("detection tick came faster than half rate");
    tick_idle_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        !run_i |-> !tick_o) else $error("detection tick while stopped");
endmodule
`default_nettype wire

// ### ced_checker.sv
// Background configuration CRC checker with error location search and error flag.
`timescale 1ns/100ps
`default_nettype none
module ced_checker #(
    parameter int FRAME_BITS = 1024,
    parameter int NUM_FRAMES = 64
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic crc_enable_i,
    input wire logic [3:0] divisor_n_i,
    input wire logic user_mode_i,
    input wire logic reconfig_request_n_i,
    input wire logic cfg_bit_i,
    input wire logic [ced_pkg::CED_CRC_W-1:0] cfg_crc_i,
    output logic [ced_pkg::CED_FRAME_W-1:0] cfg_frame_o,
    output logic [ced_pkg::CED_BIT_W-1:0] cfg_bit_idx_o,
    output logic soft_error_flag_o,
    output logic flag_pin_o,
    output logic flag_pin_oe_n_o,
    output logic [ced_pkg::CED_MSG_W-1:0] error_msg_o,
    output logic [ced_pkg::CED_MSG_W-1:0] update_reg_o,
    output logic checking_o
);
    import ced_pkg::*;

    localparam logic [CED_BIT_W-1:0] LAST_BIT = CED_BIT_W'(FRAME_BITS - 1);
    localparam logic [CED_FRAME_W-1:0] LAST_FRAME = CED_FRAME_W'(NUM_FRAMES - 1);

    function automatic logic [15:0] ced_step(input logic [15:0] c, input logic d);
        logic fb;
        fb = c[15] ^ d;
        return {c[14:0], 1'b0} ^ (fb ? CED_CRC_POLY : 16'h0000);
    endfunction

    logic rq_meta;
    logic rq_sync;
    logic tick;
    ced_state_t state, next_state;
    logic [CED_FRAME_W-1:0] frame, next_frame;
    logic [CED_BIT_W-1:0] bit_idx, next_bit_idx;
    logic [CED_BIT_W-1:0] k, next_k;
    logic [15:0] crc, next_crc;
    logic [15:0] syn, next_syn;
    logic [15:0] srch, next_srch;
    logic [CED_MSG_W-1:0] pend, next_pend;
    logic [CED_MSG_W-1:0] msg, next_msg;
    logic [CED_MSG_W-1:0] upd, next_upd;
    logic msg_wr, next_msg_wr;
    logic flag, next_flag;
    logic [5:0] guard, next_guard;
    logic en_q, next_en_q;
    logic [3:0] n_q, next_n_q;

    // The reconfiguration request comes from a pin and is synchronised first.
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rq_meta <= 1'b0;
            rq_sync <= 1'b0;
        end else begin
            rq_meta <= reconfig_request_n_i;
            rq_sync <= rq_meta;
        end
    end

    ced_clkdiv u_div (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .run_i(state != CED_IDLE),
        .div_n_i(n_q),
        .tick_o(tick)
    );

    always_comb begin
        next_state = state;
        next_frame = frame;
        next_bit_idx = bit_idx;
        next_k = k;
        next_crc = crc;
        next_syn = syn;
        next_srch = srch;
        next_pend = pend;
        next_msg = msg;
        next_msg_wr = 1'b0;
        next_flag = flag;
        next_guard = guard;
        next_en_q = en_q;
        next_n_q = n_q;
        next_upd = msg_wr ? msg : upd;
        if (flag && tick) begin
            next_flag = 1'b0;
            next_guard = CED_FLAG_LOW_TICKS;
        end else if (msg_wr) begin
            next_flag = 1'b1;
        end else if (guard != 6'h00 && tick) begin
            next_guard = guard - 6'h01;
        end
        case (state)
            CED_IDLE: begin
                // Settings are only taken while idle, so they stay fixed during checking.
                next_en_q = crc_enable_i;
                next_n_q = divisor_n_i;
                if (user_mode_i && crc_enable_i) begin
                    next_state = CED_SCAN;
                    next_frame = '0;
                    next_bit_idx = '0;
                    next_crc = CED_CRC_INIT;
                end
            end
            CED_SCAN: begin
                if (tick) begin
                    next_crc = ced_step(crc, cfg_bit_i);
                    if (bit_idx == LAST_BIT) begin
                        next_state = CED_CHECK;
                    end else begin
                        next_bit_idx = bit_idx + 1'b1;
                    end
                end
            end
            CED_CHECK: begin
                if (tick) begin
                    next_syn = crc ^ cfg_crc_i;
                    if ((crc ^ cfg_crc_i) == 16'h0000) begin
                        next_state = CED_SCAN;
                        next_frame = (frame == LAST_FRAME) ? '0 : frame + 1'b1;
                        next_bit_idx = '0;
                        next_crc = CED_CRC_INIT;
                    end else begin
                        next_state = CED_SEARCH;
                        next_srch = CED_CRC_POLY;
                        next_k = '0;
                    end
                end
            end
            CED_SEARCH: begin
                // A single bit flip k bits before the frame end leaves a known syndrome.
                if (tick) begin
                    next_pend[CED_SYN_LSB +: CED_CRC_W] = syn;
                    next_pend[CED_FRAME_LSB +: CED_FRAME_W] = frame;
                    if (syn == srch) begin
                        next_pend[CED_TYPE_LSB +: CED_TYPE_W] = CED_TYPE_SINGLE;
                        next_pend[CED_LOC_LSB +: CED_BIT_W] = LAST_BIT - k;
                        next_state = CED_WAIT;
                    end else if (k != LAST_BIT && syn == (srch ^ ced_step(srch, 1'b0))) begin
                        next_pend[CED_TYPE_LSB +: CED_TYPE_W] = CED_TYPE_DOUBLE;
                        next_pend[CED_LOC_LSB +: CED_BIT_W] = LAST_BIT - k - 1'b1;
                        next_state = CED_WAIT;
                    end else if (k == LAST_BIT) begin
                        next_pend[CED_TYPE_LSB +: CED_TYPE_W] = CED_TYPE_MULTI;
                        next_pend[CED_LOC_LSB +: CED_BIT_W] = '0;
                        next_state = CED_WAIT;
                    end else begin
                        next_srch = ced_step(srch, 1'b0);
                        next_k = k + 1'b1;
                    end
                end
            end
            CED_WAIT: begin
                // The message is held back until the flag has rested long enough.
                if (!flag && guard == 6'h00 && !msg_wr) begin
                    next_msg = pend;
                    next_msg_wr = 1'b1;
                    next_state = CED_SCAN;
                    next_frame = (frame == LAST_FRAME) ? '0 : frame + 1'b1;
                    next_bit_idx = '0;
                    next_crc = CED_CRC_INIT;
                end
            end
            default: begin
                next_state = CED_IDLE;
            end
        endcase
        if (!rq_sync) begin
            next_state = CED_IDLE;
            next_flag = 1'b0;
            next_guard = 6'h00;
            next_msg_wr = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= CED_IDLE;
            frame <= '0;
            bit_idx <= '0;
            k <= '0;
            crc <= CED_CRC_INIT;
            syn <= 16'h0000;
            srch <= CED_CRC_POLY;
            pend <= CED_MSG_RESET;
            msg <= CED_MSG_RESET;
            upd <= CED_MSG_RESET;
            msg_wr <= 1'b0;
            flag <= 1'b0;
            guard <= 6'h00;
            en_q <= 1'b0;
            n_q <= CED_DIV_N_MIN;
        end else begin
            state <= next_state;
            frame <= next_frame;
            bit_idx <= next_bit_idx;
            k <= next_k;
            crc <= next_crc;
            syn <= next_syn;
            srch <= next_srch;
            pend <= next_pend;
            msg <= next_msg;
            upd <= next_upd;
            msg_wr <= next_msg_wr;
            flag <= next_flag;
            guard <= next_guard;
            en_q <= next_en_q;
            n_q <= next_n_q;
        end
    end

    assign cfg_frame_o = frame;
    assign cfg_bit_idx_o = bit_idx;
    assign soft_error_flag_o = flag;
    assign flag_pin_o = flag;
    assign flag_pin_oe_n_o = !en_q;
    assign error_msg_o = msg;
    assign update_reg_o = upd;
    assign checking_o = (state != CED_IDLE);

    // Helper that counts detection ticks since the flag last fell.
    logic [6:0] low_cnt;
    logic seen;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_cnt <= 7'h00;
            seen <= 1'b0;
        end else if (flag) begin
            low_cnt <= 7'h00;
            seen <= 1'b1;
        end else if (tick && low_cnt != 7'h7F) begin
            low_cnt <= low_cnt + 7'h01;
        end
    end

    start_cond_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(checking_o) |-> $past(user_mode_i && crc_enable_i && rq_sync)) else $error("checking started without user mode and enable");
    flag_after_msg_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(flag) |-> $past(msg_wr)) else $error("flag rose without a message write");
    flag_low_min_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(flag) && seen |-> low_cnt >= 7'(CED_FLAG_LOW_TICKS))
        else $error("flag low phase shorter than 32 ticks");
    msg_then_flag_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || !rq_sync)
        msg_wr |-> !flag ##1 flag) else $error("message write not followed by flag");
    run_forever_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        checking_o && rq_sync |=> checking_o) else $error("checking stopped without reset");
    div_range_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        checking_o |-> n_q == $past(n_q) || $rose(checking_o)) else $error("divider changed while checking");
    frame_end_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || !rq_sync)
        state == CED_SCAN && tick && bit_idx == LAST_BIT |=> state == CED_CHECK) else $error("frame end not checked");
    msg_rewrite_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        msg_wr |-> msg == pend && msg[CED_TYPE_LSB +: CED_TYPE_W] != 4'h0) else $error("message not rewritten with result");
    update_copy_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        msg_wr |=> upd == $past(msg)) else $error("update register missed the message");
    pin_route_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        flag |-> !flag_pin_oe_n_o && flag_pin_o) else $error("flag not on the pin");
    restart_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        !rq_sync |=> state == CED_IDLE && !flag) else $error("reconfiguration did not stop checker");

    flag_seen_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) $rose(flag));
    single_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        msg_wr && msg[CED_TYPE_LSB +: CED_TYPE_W] == CED_TYPE_SINGLE);
    multi_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        msg_wr && msg[CED_TYPE_LSB +: CED_TYPE_W] == CED_TYPE_MULTI);
    second_flag_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) $rose(flag) && seen);
endmodule
`default_nettype wire

// ### ced_cfg_mem_model.sv
// Behavioural configuration memory that answers the checker's frame and bit reads.
`timescale 1ns/100ps
`default_nettype none
module ced_cfg_mem_model #(
    parameter int FRAME_BITS = 16,
    parameter int NUM_FRAMES = 4
) (
    input wire logic [ced_pkg::CED_FRAME_W-1:0] frame_i,
    input wire logic [ced_pkg::CED_BIT_W-1:0] bit_idx_i,
    input wire logic [NUM_FRAMES*FRAME_BITS-1:0] flip_i,
    output logic bit_o,
    output logic [ced_pkg::CED_CRC_W-1:0] crc_o
);
    import ced_pkg::*;
    function automatic logic clean(int f, int b);
        return ((f * 5 + b * 3) % 7) < 3;
    endfunction
    // Reference CRC is taken over the clean frame, so flips show up as syndromes.
    function automatic logic [15:0] crc_of(int f, logic [FRAME_BITS-1:0] flips);
        logic [15:0] c;
        c = CED_CRC_INIT;
        for (int b = 0; b < FRAME_BITS; b++) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ clean(f, b) ^ flips[b]) ? CED_CRC_POLY : 16'h0000);
        end
        return c;
    endfunction
    always_comb begin
        crc_o = crc_of(int'(frame_i), '0);
        if (int'(frame_i) < NUM_FRAMES && int'(bit_idx_i) < FRAME_BITS) begin
            bit_o = clean(int'(frame_i), int'(bit_idx_i)) ^ flip_i[int'(frame_i) * FRAME_BITS + int'(bit_idx_i)];
        end else begin
            bit_o = ~bit_idx_i[0];
        end
    end
endmodule
`default_nettype wire

// ### config_crc_error_detect_timing_tb_top.sv
// Self-checking testbench for the configuration error detection checker.
`timescale 1ns/100ps
`default_nettype none
module config_crc_error_detect_timing_tb_top;
    import ced_pkg::*;
    localparam int FB = 16;
    localparam int NF = 4;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic en = 1'b1;
    logic [3:0] div_n = 4'h1;
    logic um = 1'b0;
    logic rq_n = 1'b1;
    logic cbit;
    logic [15:0] ccrc;
    logic [NF*FB-1:0] flips = '0;
    logic [13:0] cfg_frame_o;
    logic [11:0] cfg_bit_idx_o;
    logic soft_error_flag_o, flag_pin_o, flag_pin_oe_n_o, checking_o;
    logic [45:0] error_msg_o, update_reg_o;
    int err_total = 0;
    int n_tests = 0;
    ced_checker #(.FRAME_BITS(FB), .NUM_FRAMES(NF)) uut (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
        .crc_enable_i(en), .divisor_n_i(div_n), .user_mode_i(um), .reconfig_request_n_i(rq_n),
        .cfg_bit_i(cbit), .cfg_crc_i(ccrc), .cfg_frame_o(cfg_frame_o), .cfg_bit_idx_o(cfg_bit_idx_o),
        .soft_error_flag_o(soft_error_flag_o), .flag_pin_o(flag_pin_o),
        .flag_pin_oe_n_o(flag_pin_oe_n_o), .error_msg_o(error_msg_o), .update_reg_o(update_reg_o),
        .checking_o(checking_o));
    ced_cfg_mem_model #(.FRAME_BITS(FB), .NUM_FRAMES(NF)) mem (.frame_i(cfg_frame_o),
        .bit_idx_i(cfg_bit_idx_o), .flip_i(flips), .bit_o(cbit), .crc_o(ccrc));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic restart(logic e, logic [3:0] n);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        en <= e;
        div_n <= n;
        cyc(2);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        cyc(1);
    endtask
    // Waits for the flag to reach the given level; a miss counts as a mismatch.
    task automatic wait_flag(logic lvl, int lim, output int c);
        c = 0;
        while (soft_error_flag_o !== lvl && c < lim) begin
            cyc(1);
            c++;
        end
        chk("flag level", lvl, soft_error_flag_o);
    endtask
    // The CRC is linear, so the syndrome is the zero-seeded CRC of the flip pattern alone.
    function automatic logic [45:0] exp_msg(logic [3:0] t, int f, int b, logic [FB-1:0] fl);
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < FB; i++) begin
            s = {s[14:0], 1'b0} ^ ((s[15] ^ fl[i]) ? CED_CRC_POLY : 16'h0000);
        end
        return {t, 14'(f), 12'(b), s};
    endfunction
    task automatic t_start();
        int hi, wraps, t0, t1;
        logic [13:0] prev;
        hi = 0;
        wraps = 0;
        t0 = 0;
        t1 = 0;
        cyc(10);
        chk("checking before user mode", 1'b0, checking_o);
        @(posedge sys_clk);
        um <= 1'b1;
        cyc(8);
        chk("checking after user mode", 1'b1, checking_o);
        chk("pin enable", 1'b0, flag_pin_oe_n_o);
        for (int i = 0; i < 400; i++) begin
            prev = cfg_frame_o;
            cyc(1);
            if (soft_error_flag_o !== 1'b0) hi++;
            if (prev === 14'(NF - 1) && cfg_frame_o === 14'h0000) begin
                wraps++;
                if (wraps == 1) t0 = i;
                if (wraps == 2) t1 = i;
            end
        end
        chk("flag cycles on clean scan", 0, hi);
        chk("frames revisited", 1'b1, wraps >= 2);
        chk("full pass cycles", NF * (FB + 1) * 2, t1 - t0);
        $display("test start done");
    endtask
    task automatic t_two_errors();
        int c;
        @(posedge sys_clk);
        flips <= '0 | (64'h1 << (2 * FB + 5)) | (64'h1 << (3 * FB + 10));
        wait_flag(1'b1, 400, c);
        chk("first message", exp_msg(CED_TYPE_SINGLE, 2, 5, 16'h0020), error_msg_o);
        chk("first update copy", exp_msg(CED_TYPE_SINGLE, 2, 5, 16'h0020), update_reg_o);
        chk("pin follows flag", 1'b1, flag_pin_o);
        wait_flag(1'b0, 8, c);
        wait_flag(1'b1, 400, c);
        chk("low time at least 32 ticks", 1'b1, c >= 2 * CED_FLAG_LOW_TICKS);
        chk("second message", exp_msg(CED_TYPE_SINGLE, 3, 10, 16'h0400), error_msg_o);
        $display("test two errors done");
    endtask
    task automatic t_recover();
        int c, hi;
        hi = 0;
        @(posedge sys_clk);
        flips <= '0;
        rq_n <= 1'b0;
        cyc(3);
        @(posedge sys_clk);
        rq_n <= 1'b1;
        cyc(1);
        chk("flag after request", 1'b0, soft_error_flag_o);
        chk("checking during request", 1'b0, checking_o);
        chk("message kept", exp_msg(CED_TYPE_SINGLE, 3, 10, 16'h0400), error_msg_o);
        cyc(8);
        chk("checking resumed", 1'b1, checking_o);
        for (int i = 0; i < 300; i++) begin
            cyc(1);
            if (soft_error_flag_o !== 1'b0) hi++;
        end
        chk("flag after repair", 0, hi);
        @(posedge sys_clk);
        flips <= 64'h3 << (FB + 7);
        wait_flag(1'b1, 400, c);
        chk("double message", exp_msg(CED_TYPE_DOUBLE, 1, 7, 16'h0180), error_msg_o);
        $display("test recover done");
    endtask
    // Three adjacent flips match neither a single nor a double pattern.
    task automatic t_multi();
        int c;
        restart(1'b1, 4'h1);
        @(posedge sys_clk);
        flips <= 64'h7 << 4;
        wait_flag(1'b1, 400, c);
        chk("multi message", exp_msg(CED_TYPE_MULTI, 0, 0, 16'h0070), error_msg_o);
        chk("multi update copy", exp_msg(CED_TYPE_MULTI, 0, 0, 16'h0070), update_reg_o);
        $display("test multi done");
    endtask
    task automatic idx_gap(output int c);
        logic [11:0] p;
        p = cfg_bit_idx_o;
        c = 0;
        while (cfg_bit_idx_o === p && c < 600) begin
            cyc(1);
            c++;
        end
    endtask
    task automatic t_divisor();
        int ns[5] = '{0, 1, 3, 8, 9};
        int ex[5] = '{2, 2, 8, 256, 256};
        int c;
        @(posedge sys_clk);
        flips <= '0;
        for (int k = 0; k < 5; k++) begin
            restart(1'b1, 4'(ns[k]));
            cyc(4);
            idx_gap(c);
            idx_gap(c);
            chk("tick spacing", ex[k], c);
        end
        restart(1'b0, 4'h1);
        cyc(50);
        chk("checking when disabled", 1'b0, checking_o);
        chk("pin released when disabled", 1'b1, flag_pin_oe_n_o);
        $display("test divisor done");
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk);
        err_total++;
        $display("Error watchdog expected finish seen timeout");
        stop_test();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_start();
        t_two_errors();
        t_recover();
        t_multi();
        t_divisor();
        stop_test();
    end
endmodule
`default_nettype wire
